// >>> hdl/vsync_timing.v
// Strobed register access is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
`include "vsync_consts.vh"
// Vertical non-display and sync pulse generator for the CRT/TV pipe.
// Line boundaries and the display-end point come from horizontal and
// vertical display timing elsewhere; this block owns only the blank tail.
module vsync_timing (
	input wire clk_sys,
	input wire rst_b,
	input wire ce,
	input wire line_end,
	input wire display_done,
	input wire [`ADDR_W-1:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	output wire vertical_sync_pulse,
	output wire blank_active,
	output wire frame_start,
	output wire irq
);
	reg [6:0] blank_height_r;
	reg [6:0] sync_start_r;
	reg [2:0] sync_width_r;
	reg sync_pol_r;
	reg [`IRQ_W-1:0] irq_mask_r;
	reg blank_r;
	reg sync_r;
	reg [7:0] rdata_nxt;
	wire [7:0] line_cnt;
	wire [`IRQ_W-1:0] irq_status;
	wire [`IRQ_W-1:0] irq_clear;
	wire blank_start;
	wire blank_end;
	wire sync_on;
	wire sync_off;
	wire [`IRQ_W-1:0] irq_events;

	// Field plus one, widened so 127 + 1 cannot wrap
	function [7:0] plus_one;
		input [6:0] f;
		begin
			plus_one = {1'b0, f} + 8'h01;
		end
	endfunction

	// Configuration writes; status bit is not writable
	always @(posedge clk_sys) begin
		if (!rst_b) begin
			blank_height_r <= `RST_BLANK;
			sync_start_r <= `RST_START;
			sync_width_r <= `RST_WIDTH;
			sync_pol_r <= `RST_POL;
			irq_mask_r <= {`IRQ_W{1'b0}};
		end else if (ce && reg_wr) begin
			if (reg_addr == `OFS_BLANK) begin
				blank_height_r <= reg_wdata[6:0];
			end else if (reg_addr == `OFS_START) begin
				sync_start_r <= reg_wdata[6:0];
			end else if (reg_addr == `OFS_WIDTH) begin
				sync_width_r <= reg_wdata[2:0];
				sync_pol_r <= reg_wdata[`BIT_POL];
			end else if (reg_addr == `OFS_IRQ_MASK) begin
				irq_mask_r <= reg_wdata[`IRQ_W-1:0];
			end
		end
	end

	// Line counter: 1 on the first blank line, then counts up
	vsync_line_counter #(
		.CNT_W(7)
	) u_cnt (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.ce(ce),
		.line_end(line_end),
		.blank_start(blank_start),
		.line_cnt_r(line_cnt)
	);

	// Blank begins at the line boundary that ends the display area
	assign blank_start = line_end && display_done && !blank_r;
	// Blank ends after height plus one whole lines; at-or-past so a
	// height rewritten below the running count cannot hang the blank
	assign blank_end = line_end && blank_r
		&& (line_cnt >= plus_one(blank_height_r));
	// Sync leads after start plus one lines, never on the closing line
	assign sync_on = line_end && blank_r && !sync_r && !blank_end
		&& (line_cnt == plus_one(sync_start_r));
	// Lasts width plus one lines; at-or-past for the same rewrite hazard
	assign sync_off = line_end && sync_r
		&& (line_cnt >= plus_one(sync_start_r) + plus_one({4'h0, sync_width_r}));

	// Blank and sync state move only on line boundaries
	always @(posedge clk_sys) begin
		if (!rst_b) begin
			blank_r <= 1'b0;
			sync_r <= 1'b0;
		end else if (ce) begin
			if (blank_start) begin
				blank_r <= 1'b1;
			end else if (blank_end) begin
				blank_r <= 1'b0;
			end
			// Forced off at blank end if software broke the sizing
			if (sync_on) begin
				sync_r <= 1'b1;
			end else if (sync_off || blank_end) begin
				sync_r <= 1'b0;
			end
		end
	end

	// Polarity applied after the state, TV needs the bit at zero
	assign vertical_sync_pulse = sync_pol_r ? sync_r : ~sync_r;
	assign blank_active = blank_r;
	assign frame_start = ce && blank_end;

	// Interrupt events and write-one-to-clear
	assign irq_events[`IRQ_BLANK_BEG] = ce && blank_start;
	assign irq_events[`IRQ_SYNC_BEG] = ce && sync_on;
	assign irq_clear = (reg_wr && reg_addr == `OFS_IRQ_STAT)
		? reg_wdata[`IRQ_W-1:0] : {`IRQ_W{1'b0}};

	vsync_irq #(
		.W(`IRQ_W)
	) u_irq (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.ce(ce),
		.event_set(irq_events),
		.clear_ones(irq_clear),
		.mask_bits(irq_mask_r),
		.status_r(irq_status),
		.irq(irq)
	);

	// Read mux, unmapped addresses read zero
	always @* begin
		rdata_nxt = 8'h00;
		if (reg_addr == `OFS_BLANK) begin
			rdata_nxt = {blank_r, blank_height_r};
		end else if (reg_addr == `OFS_START) begin
			rdata_nxt = {1'b0, sync_start_r};
		end else if (reg_addr == `OFS_WIDTH) begin
			rdata_nxt = {sync_pol_r, 4'h0, sync_width_r};
		end else if (reg_addr == `OFS_IRQ_STAT) begin
			rdata_nxt = {6'h00, irq_status};
		end else if (reg_addr == `OFS_IRQ_MASK) begin
			rdata_nxt = {6'h00, irq_mask_r};
		end
	end

	// Read data registered, valid the cycle after the strobe
	always @(posedge clk_sys) begin
		if (!rst_b) begin
			reg_rdata <= 8'h00;
		end else if (ce) begin
			reg_rdata <= reg_rd ? rdata_nxt : 8'h00;
		end
	end
endmodule // vsync_timing
`default_nettype wire

// >>> hdl/vsync_consts.vh
// Function
// - Status flag reads 1 inside vertical non-display period, 0 in display period.
// - Non-display period height equals 7-bit field plus one lines.
// - Sync leading edge comes start field plus one lines after blank start.
// - Sync pulse lasts 3-bit width field plus one lines.
// - Polarity bit 1 gives active-high sync, 0 gives active-low sync.
// - Writes to the status bit position leave the status unchanged.
`ifndef VSYNC_CONSTS_VH
`define VSYNC_CONSTS_VH
`define ADDR_W 8
`define OFS_BLANK 8'h58
`define OFS_START 8'h59
`define OFS_WIDTH 8'h5a
`define OFS_IRQ_STAT 8'h5c
`define OFS_IRQ_MASK 8'h5d
`define BIT_FLAG 7
`define BIT_POL 7
`define RST_BLANK 7'h00
`define RST_START 7'h00
`define RST_WIDTH 3'h0
`define RST_POL 1'h0
`define IRQ_W 2
`define IRQ_BLANK_BEG 0
`define IRQ_SYNC_BEG 1
`endif

// >>> hdl/vsync_line_counter.v
`timescale 1ns/10ps
`default_nettype none
`include "vsync_consts.vh"
// Counts lines inside the non-display period
module vsync_line_counter #(
	parameter CNT_W = 7
) (
	input wire clk_sys,
	input wire rst_b,
	input wire ce,
	input wire line_end,
	input wire blank_start,
	output reg [CNT_W:0] line_cnt_r
);
	// Restart at one on blank entry, saturate to avoid wrap
	always @(posedge clk_sys) begin
		if (!rst_b) begin
			line_cnt_r <= {(CNT_W+1){1'b0}};
		end else if (ce && line_end) begin
			if (blank_start) begin
				line_cnt_r <= {{CNT_W{1'b0}}, 1'b1};
			end else if (line_cnt_r != {(CNT_W+1){1'b1}}) begin
				line_cnt_r <= line_cnt_r + 1'b1;
			end
		end
	end
endmodule // vsync_line_counter
`default_nettype wire

// >>> hdl/vsync_irq.v
`timescale 1ns/10ps
`default_nettype none
`include "vsync_consts.vh"
// Sticky status with write-one-to-clear and mask
module vsync_irq #(
	parameter W = 2
) (
	input wire clk_sys,
	input wire rst_b,
	input wire ce,
	input wire [W-1:0] event_set,
	input wire [W-1:0] clear_ones,
	input wire [W-1:0] mask_bits,
	output reg [W-1:0] status_r,
	output wire irq
);
	// Set wins over a same-cycle clear so no event is lost
	always @(posedge clk_sys) begin
		if (!rst_b) begin
			status_r <= {W{1'b0}};
		end else if (ce) begin
			status_r <= (status_r & ~clear_ones) | event_set;
		end
	end
	assign irq = |(status_r & mask_bits);
endmodule // vsync_irq
`default_nettype wire

// >>> sim/vsync_timing_properties.sv
`timescale 1ns/10ps
`default_nettype none
// Sees only the top-level pins; ce is tied high by the bench
module vsync_checker (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic ce,
	input wire logic line_end,
	input wire logic display_done,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic vertical_sync_pulse,
	input wire logic blank_active,
	input wire logic frame_start,
	input wire logic irq
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	// A polarity write may also flip the pin, so it is allowed too
	a_sync_on_line: assert property ($changed(vertical_sync_pulse) |-> $past(line_end) || $past(reg_wr))
		else $error("sync moved off a line edge");
	// Pin must stay put through the display area unless software rewrites it
	a_quiet_display: assert property (!blank_active && !$past(blank_active) && !$past(reg_wr) |-> $stable(vertical_sync_pulse))
		else $error("sync moved during display");
	a_blank_begin: assert property (ce && line_end && display_done && !blank_active |=> blank_active)
		else $error("blank did not begin");
	a_blank_end: assert property (frame_start |-> line_end && blank_active ##1 !blank_active)
		else $error("blank did not end");
	a_blank_steady: assert property (!line_end |=> $stable(blank_active))
		else $error("blank moved off a line edge");
	a_flag_ro: assert property (reg_wr && reg_addr == 8'h58 && !line_end |=> $stable(blank_active))
		else $error("status bit took a write");
	a_flag_read: assert property (ce && reg_rd && reg_addr == 8'h58 |=> reg_rdata[7] == $past(blank_active))
		else $error("status bit misread");
	a_read_idle: assert property (ce && !reg_rd |=> reg_rdata == 8'h00)
		else $error("read data not cleared");
endmodule // vsync_checker
bind vsync_timing vsync_checker u_vsync_checker (
	.clk_sys(clk_sys),
	.rst_b(rst_b),
	.ce(ce),
	.line_end(line_end),
	.display_done(display_done),
	.reg_wr(reg_wr),
	.reg_rd(reg_rd),
	.reg_addr(reg_addr),
	.reg_wdata(reg_wdata),
	.reg_rdata(reg_rdata),
	.vertical_sync_pulse(vertical_sync_pulse),
	.blank_active(blank_active),
	.frame_start(frame_start),
	.irq(irq)
);
`default_nettype wire

// >>> sim/crt_monitor.sv
`timescale 1ns/10ps
`default_nettype none
// Monitor side: measures sync lead and length in whole lines
module crt_monitor (
	input wire logic clk_sys,
	input wire logic line_end,
	input wire logic blank_active,
	input wire logic vertical_sync_pulse,
	input wire logic pol,
	output logic [7:0] pos_r,
	output logic [7:0] lead_r,
	output logic [7:0] len_r
);
	wire act = (vertical_sync_pulse == pol); // Active level set by polarity
	// Restart each blank so a stale frame cannot leak in
	always @(posedge clk_sys) begin
		if (!blank_active) begin
			pos_r <= 8'h00;
			len_r <= 8'h00;
		end else begin
			if (line_end) pos_r <= pos_r + 8'h01;
			if (act && line_end) len_r <= len_r + 8'h01;
			if (act && len_r == 8'h00) lead_r <= pos_r;
		end
	end
endmodule // crt_monitor
`default_nettype wire

// >>> sim/test_vsync_timing.sv
`timescale 1ns/10ps
`default_nettype none
module test_vsync_timing;
	logic clk_sys = 0, rst_b = 0, line_end = 0, display_done = 1, reg_wr = 0, reg_rd = 0, pol = 0;
	logic [7:0] reg_addr = 0, reg_wdata = 0, h, s, w;
	wire logic [7:0] reg_rdata, pos_r, lead_r, len_r;
	wire logic vertical_sync_pulse, blank_active, frame_start, irq;
	wire logic ce = 1'b1;
	integer err_total = 0, cmp_count = 0, seed = 64, cyc = 0;
	vsync_timing u_vsync_timing (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.ce(ce),
		.line_end(line_end),
		.display_done(display_done),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.vertical_sync_pulse(vertical_sync_pulse),
		.blank_active(blank_active),
		.frame_start(frame_start),
		.irq(irq)
	);
	crt_monitor u_crt_monitor (
		.clk_sys(clk_sys),
		.line_end(line_end),
		.blank_active(blank_active),
		.vertical_sync_pulse(vertical_sync_pulse),
		.pol(pol),
		.pos_r(pos_r),
		.lead_r(lead_r),
		.len_r(len_r)
	);
	always #5 clk_sys = ~clk_sys;
	// Line edge every eight cycles; hang guard
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		line_end <= (cyc % 8 == 7);
		if (cyc == 30000) begin
			err_total = err_total + 1;
			final_report;
		end
	end
	task chk(input string n, input [7:0] e, g);
		cmp_count = cmp_count + 1;
		if (g !== e) begin
			$display("[ERR] %s exp %h got %h", n, e, g);
			err_total = err_total + 1;
		end
	endtask
	task wr(input [7:0] a, d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1;
		@(posedge clk_sys);
		reg_wr <= 0;
	endtask
	task rd(input string n, input [7:0] a, e);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1;
		@(posedge clk_sys);
		reg_rd <= 0;
		#1 chk(n, e, reg_rdata);
	endtask
	// Frame end is a one-cycle pulse, so look after every edge
	task wait_frame;
		do begin
			@(posedge clk_sys);
			#1;
		end while (frame_start !== 1'b1);
		// Let the closing line edge land in the monitor counts
		@(posedge clk_sys);
		#1;
	endtask
	task final_report;
		$display("compares %0d errors %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge clk_sys);
		rst_b <= 1;
		#1 chk("idle pin", 8'h01, {7'h00, vertical_sync_pulse});
		rd("start", 8'h59, 8'h00);
		rd("unmapped", 8'h5b, 8'h00);
		// First two passes are the tightest corners
		for (int k = 0; k < 6; k++) begin
			w = $random(seed) & 7;
			s = $random(seed) & 15;
			h = s + w + 1 + (k == 1 ? 0 : $random(seed) & 7);
			pol = (k > 1) & $random(seed);
			if (k == 0) {h, s, w} = 24'h01_0000;
			wr(8'h58, {~pol, h[6:0]});
			wr(8'h59, s);
			wr(8'h5a, {pol, 4'h0, w[2:0]});
			rd("width", 8'h5a, {pol, 4'h0, w[2:0]});
			wait_frame;
			wait_frame;
			chk("height", h + 8'h01, pos_r);
			chk("lead", s + 8'h01, lead_r);
			chk("len", w + 8'h01, len_r);
			rd("flag", 8'h58, {1'b0, h[6:0]});
			chk("pin", {7'h00, ~pol}, {7'h00, vertical_sync_pulse});
			repeat (10) @(posedge clk_sys);
			rd("flag", 8'h58, {1'b1, h[6:0]});
		end
		display_done <= 0;
		wait_frame;
		wr(8'h5c, 8'h03);
		rd("status", 8'h5c, 8'h00);
		wr(8'h5d, 8'h03);
		#1 chk("irq", 8'h00, {7'h00, irq});
		display_done <= 1;
		wait_frame;
		chk("irq", 8'h01, {7'h00, irq});
		rd("status", 8'h5c, 8'h03);
		wr(8'h5d, 8'h00);
		#1 chk("irq", 8'h00, {7'h00, irq});
		final_report;
	end
endmodule // test_vsync_timing
`default_nettype wire
